//--- ptdxr_regs.sv
// register slice 0x17..0x1e: lock pin test mux, first output prescaler,
// receiver reset, band gap trim and crystal tuning.
// assumes the serial engine presents one-cycle write and read strobes on
// CLOCK; lock and test sources arrive asynchronous and are synchronised.
`timescale 1ns/1ps
`default_nettype none
module ptdxr_regs
  import ptdxr_pkg::*;
#(
  parameter int RX_HOLD = RX_RESET_CYCLES
) (
  input  wire logic                     CLOCK,
  input  wire logic                     NRST,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  input  wire logic [ADDR_W-1:0]        REG_ADDR,
  input  wire logic [DATA_W-1:0]        REG_WDATA,
  output logic      [DATA_W-1:0]        REG_RDATA,
  input  wire logic                     OUTDIV_OVERRIDE,
  input  wire logic [PRESC_W-1:0]       PIN_PRESCALER_CODE,
  input  wire logic                     PLL_LOCKED,
  input  wire ptdxr_test_src_t          TEST_SRC,
  output logic                          LOCK_PIN,
  output logic      [PRESC_W-1:0]       PRESCALER_CODE,
  output logic      [3:0]               PRESCALER_RATIO,
  output logic                          PRESCALER_INVALID,
  output logic                          RX_RESET,
  output var ptdxr_analog_cfg_t         ANALOG_CFG
);

  // reset release
  logic                   rst_meta_r;
  logic                   rst_n;

  // stored fields
  logic                   test_en_r;
  logic [TEST_SEL_W-1:0]  test_sel_r;
  logic [PRESC_W-1:0]     presc_r;
  logic [BANDGAP_W-1:0]   bandgap_r;
  logic                   bandgap_en_r;
  logic                   crystal_resonator_input_auto_r;
  logic [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0] crystal_resonator_input_tune_r;
  logic [RX_CNT_W-1:0]    rx_cnt_r;
  logic [RX_CNT_W-1:0]    rx_cnt_nxt;
  logic                   rx_reset_r;
  logic                   rx_reset_nxt;

  // synchronised asynchronous inputs
  logic                   locked_s;
  ptdxr_test_src_t        src_s;

  // decode
  wire                    wr_test;
  wire                    wr_presc;
  wire                    wr_rx;
  wire                    wr_crystal_resonator_input;
  wire                    rx_kick;
  wire                    sel_test;
  wire                    sel_presc;
  wire                    sel_rx;
  wire                    sel_crystal_resonator_input;
  wire [DATA_W-1:0]       rd_test;
  wire [DATA_W-1:0]       rd_presc;
  wire [DATA_W-1:0]       rd_rx;
  wire [DATA_W-1:0]       rd_crystal_resonator_input;
  wire [DATA_W-1:0]       rd_mux;
  wire                    test_bit;
  wire                    lock_nxt;
  wire [PRESC_W-1:0]      presc_eff;
  wire                    presc_bad;
  wire [3:0]              ratio_eff;

  // write data fields
  wire                    wd_test_en;
  wire [TEST_SEL_W-1:0]   wd_test_sel;
  wire [PRESC_W-1:0]      wd_presc;
  wire [BANDGAP_W-1:0]    wd_bandgap;
  wire                    wd_bandgap_en;
  wire                    wd_crystal_resonator_input_auto;
  wire [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0]  wd_crystal_resonator_input_tune;

  // analog next values
  wire                    bg_auto_nxt;
  wire [BANDGAP_W-1:0]    bg_code_nxt;
  wire                    xt_auto_nxt;
  wire [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0]  xt_code_nxt;
  wire [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0]  xt_cap_nxt;
  wire ptdxr_analog_cfg_t analog_nxt;

  // reset: async assert, two-flop release
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  ptdxr_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h00)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .d     ({PLL_LOCKED, TEST_SRC}),
    .q     ({locked_s, src_s})
  );

  // write decode
  assign wr_test  = REG_WR && (REG_ADDR == TEST_OUTPUT_SELECT_ADDR);
  assign wr_presc = REG_WR && (REG_ADDR == OUTPUT_PRESCALER_SELECT_ADDR);
  assign wr_rx    = REG_WR && (REG_ADDR == RECEIVER_BANDGAP_CONTROL_ADDR);
  assign wr_crystal_resonator_input  = REG_WR && (REG_ADDR == CRYSTAL_TUNING_CONTROL_ADDR);
  assign rx_kick  = wr_rx && REG_WDATA[RX_RESET_BIT];

  // write data fields
  assign wd_test_en    = REG_WDATA[TEST_EN_BIT];
  assign wd_test_sel   = REG_WDATA[TEST_SEL_LSB +: TEST_SEL_W];
  assign wd_presc      = REG_WDATA[PRESC_LSB +: PRESC_W];
  assign wd_bandgap    = REG_WDATA[BANDGAP_LSB +: BANDGAP_W];
  assign wd_bandgap_en = REG_WDATA[BANDGAP_EN_BIT];
  assign wd_crystal_resonator_input_auto  = REG_WDATA[CRYSTAL_RESONATOR_INPUT_AUTO_BIT];
  // bit 6 is not stored; writers keep it zero
  assign wd_crystal_resonator_input_tune  = REG_WDATA[CRYSTAL_RESONATOR_INPUT_TUNE_LSB +: CRYSTAL_RESONATOR_INPUT_TUNE_W];

  // one flop block per field
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      test_en_r <= TEST_EN_RST;
    end else if (wr_test) begin
      test_en_r <= wd_test_en;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      test_sel_r <= TEST_SEL_RST;
    end else if (wr_test) begin
      test_sel_r <= wd_test_sel;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= PRESC_RST;
    end else if (wr_presc) begin
      presc_r <= wd_presc;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_r <= BANDGAP_RST;
    end else if (wr_rx) begin
      bandgap_r <= wd_bandgap;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_en_r <= BANDGAP_EN_RST;
    end else if (wr_rx) begin
      bandgap_en_r <= wd_bandgap_en;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      crystal_resonator_input_auto_r <= CRYSTAL_RESONATOR_INPUT_AUTO_RST;
    end else if (wr_crystal_resonator_input) begin
      crystal_resonator_input_auto_r <= wd_crystal_resonator_input_auto;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      crystal_resonator_input_tune_r <= CRYSTAL_RESONATOR_INPUT_TUNE_RST;
    end else if (wr_crystal_resonator_input) begin
      crystal_resonator_input_tune_r <= wd_crystal_resonator_input_tune;
    end
  end

  // receiver reset: self-clearing hold of RX_HOLD cycles
  always_comb begin
    rx_cnt_nxt   = rx_cnt_r;
    rx_reset_nxt = rx_reset_r;
    if (rx_kick) begin
      rx_cnt_nxt   = RX_CNT_W'(RX_HOLD - 1);
      rx_reset_nxt = 1'b1;
    end else if (rx_cnt_r != '0) begin
      rx_cnt_nxt   = rx_cnt_r - 1'b1;
    end else begin
      rx_reset_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r <= '0;
    end else begin
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rx_reset_r <= 1'b0;
    end else begin
      rx_reset_r <= rx_reset_nxt;
    end
  end

  assign RX_RESET = rx_reset_r;

  // lock pin test mux
  assign test_bit = (test_sel_r == PTDXR_SEL_OSC)          ? src_s.crystal_osc_output :
                    (test_sel_r == PTDXR_SEL_PUMP_UP_HALF) ? src_s.pump_up_half :
                    (test_sel_r == PTDXR_SEL_REF_HALF)     ? src_s.detector_ref_half :
                                                             src_s.detector_feedback_half;
  assign lock_nxt = test_en_r ? test_bit : locked_s;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      LOCK_PIN <= 1'b0;
    end else begin
      LOCK_PIN <= lock_nxt;
    end
  end

  // prescaler selection
  assign presc_eff = OUTDIV_OVERRIDE ? presc_r : PIN_PRESCALER_CODE;
  assign presc_bad = (presc_eff == PRESC_INVALID_CODE);
  assign ratio_eff = presc_bad ? 4'h0 : ({1'b0, presc_eff} + PRESC_RATIO_OFFSET);

  // registered prescaler outputs
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRESCALER_CODE <= PRESC_RST;
    end else begin
      PRESCALER_CODE <= presc_eff;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRESCALER_RATIO <= {1'b0, PRESC_RST} + PRESC_RATIO_OFFSET;
    end else begin
      PRESCALER_RATIO <= ratio_eff;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRESCALER_INVALID <= 1'b0;
    end else begin
      PRESCALER_INVALID <= presc_bad;
    end
  end

  // analog settings; a disabled override shows the reset code
  assign bg_auto_nxt = ~bandgap_en_r;
  assign bg_code_nxt = bandgap_en_r ? bandgap_r : BANDGAP_RST;
  assign xt_auto_nxt = crystal_resonator_input_auto_r;
  assign xt_code_nxt = crystal_resonator_input_auto_r ? CRYSTAL_RESONATOR_INPUT_TUNE_RST : crystal_resonator_input_tune_r;
  assign xt_cap_nxt  = ~xt_code_nxt;
  assign analog_nxt  = {bg_auto_nxt, bg_code_nxt, xt_auto_nxt, xt_code_nxt, xt_cap_nxt};

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ANALOG_CFG <= '{bandgap_auto: ~BANDGAP_EN_RST, bandgap_code: BANDGAP_RST,
                      crystal_resonator_input_auto: CRYSTAL_RESONATOR_INPUT_AUTO_RST, crystal_resonator_input_code: CRYSTAL_RESONATOR_INPUT_TUNE_RST,
                      crystal_resonator_input_cap_quarter_pf: ~CRYSTAL_RESONATOR_INPUT_TUNE_RST};
    end else begin
      ANALOG_CFG <= analog_nxt;
    end
  end

  // read path, unused bits and blocks read zero
  assign sel_test  = (REG_ADDR == TEST_OUTPUT_SELECT_ADDR);
  assign sel_presc = (REG_ADDR == OUTPUT_PRESCALER_SELECT_ADDR);
  assign sel_rx    = (REG_ADDR == RECEIVER_BANDGAP_CONTROL_ADDR);
  assign sel_crystal_resonator_input  = (REG_ADDR == CRYSTAL_TUNING_CONTROL_ADDR);
  assign rd_test   = {4'h0, test_en_r, test_sel_r, 1'b0};
  assign rd_presc  = {presc_r, 5'h00};
  assign rd_rx     = {rx_reset_r, bandgap_r, 1'b0, bandgap_en_r};
  assign rd_crystal_resonator_input   = {crystal_resonator_input_auto_r, 1'b0, crystal_resonator_input_tune_r};
  assign rd_mux    = sel_test  ? rd_test  :
                     sel_presc ? rd_presc :
                     sel_rx    ? rd_rx    :
                     sel_crystal_resonator_input  ? rd_crystal_resonator_input  : 8'h00;

  // read data holds until the next read strobe
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

endmodule : ptdxr_regs
`default_nettype wire

//--- ptdxr_pkg.sv
// constants, field layouts and carrier types of the pll test, prescaler,
// receiver and crystal register slice.
// assumes an 8-bit register port from the serial engine on the same clock.
package ptdxr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] TEST_OUTPUT_SELECT_ADDR       = 8'h17;
  localparam logic [7:0] OUTPUT_PRESCALER_SELECT_ADDR  = 8'h18;
  localparam logic [7:0] RESERVED_BLOCK_19_ADDR        = 8'h19;
  localparam logic [7:0] RECEIVER_BANDGAP_CONTROL_ADDR = 8'h1A;
  localparam logic [7:0] CRYSTAL_TUNING_CONTROL_ADDR   = 8'h1B;
  localparam logic [7:0] RESERVED_BLOCK_1C_ADDR        = 8'h1C;
  localparam logic [7:0] RESERVED_BLOCK_1D_ADDR        = 8'h1D;
  localparam logic [7:0] RESERVED_BLOCK_1E_ADDR        = 8'h1E;

  // field positions
  localparam int TEST_EN_BIT      = 3;
  localparam int TEST_SEL_LSB     = 1;
  localparam int TEST_SEL_W       = 2;
  localparam int PRESC_LSB        = 5;
  localparam int PRESC_W          = 3;
  localparam int RX_RESET_BIT     = 7;
  localparam int BANDGAP_LSB      = 2;
  localparam int BANDGAP_W        = 5;
  localparam int BANDGAP_EN_BIT   = 0;
  localparam int CRYSTAL_RESONATOR_INPUT_AUTO_BIT    = 7;
  localparam int CRYSTAL_RESONATOR_INPUT_TUNE_LSB    = 0;
  localparam int CRYSTAL_RESONATOR_INPUT_TUNE_W      = 6;

  // reset values
  localparam logic                   TEST_EN_RST    = 1'b0;
  localparam logic [TEST_SEL_W-1:0]  TEST_SEL_RST   = 2'h0;
  localparam logic [PRESC_W-1:0]     PRESC_RST      = 3'h1;
  localparam logic [BANDGAP_W-1:0]   BANDGAP_RST    = 5'h00;
  localparam logic                   BANDGAP_EN_RST = 1'b0;
  localparam logic                   CRYSTAL_RESONATOR_INPUT_AUTO_RST  = 1'b1;
  localparam logic [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0] CRYSTAL_RESONATOR_INPUT_TUNE_RST  = 6'h00;

  // prescaler coding
  localparam logic [PRESC_W-1:0] PRESC_INVALID_CODE = 3'h0;
  localparam logic [3:0]         PRESC_RATIO_OFFSET = 4'h4;

  // crystal tuning step in femtofarads, so 0.25 pF
  localparam int CRYSTAL_RESONATOR_INPUT_STEP_FF = 250;

  // receiver reset hold, in clock cycles
  localparam int RX_RESET_CYCLES = 4;
  localparam int RX_CNT_W        = 3;

  typedef enum logic [1:0] {
    PTDXR_SEL_OSC,
    PTDXR_SEL_PUMP_UP_HALF,
    PTDXR_SEL_REF_HALF,
    PTDXR_SEL_FEEDBACK_HALF
  } ptdxr_test_sel_t;

  // observable test sources, all from outside this clock domain
  typedef struct packed {
    logic detector_feedback_half;
    logic detector_ref_half;
    logic pump_up_half;
    logic crystal_osc_output;
  } ptdxr_test_src_t;

  // band gap and crystal settings handed to the analog side
  typedef struct packed {
    logic                   bandgap_auto;
    logic [BANDGAP_W-1:0]   bandgap_code;
    logic                   crystal_resonator_input_auto;
    logic [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0] crystal_resonator_input_code;
    logic [CRYSTAL_RESONATOR_INPUT_TUNE_W-1:0] crystal_resonator_input_cap_quarter_pf;
  } ptdxr_analog_cfg_t;

endpackage : ptdxr_pkg

//--- ptdxr_sync.sv
// two-flop synchroniser bank for levels from another domain.
// assumes the destination clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ptdxr_sync #(
  parameter int           WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // meta_r feeds only q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : ptdxr_sync
`default_nettype wire

//--- ptdxr_regs_checker.sv
// assertions on the pll test, prescaler, receiver and crystal register slice.
// assumes binding onto ptdxr_regs; writes come only after reset release.
`timescale 1ns/1ps
`default_nettype none
module ptdxr_regs_checker
  import ptdxr_pkg::*;
#(
  parameter int RX_HOLD = RX_RESET_CYCLES
) (
  input wire logic               CLOCK,
  input wire logic               NRST,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire logic [ADDR_W-1:0]  REG_ADDR,
  input wire logic [DATA_W-1:0]  REG_WDATA,
  input wire logic [DATA_W-1:0]  REG_RDATA,
  input wire logic               OUTDIV_OVERRIDE,
  input wire logic [PRESC_W-1:0] PIN_PRESCALER_CODE,
  input wire logic               PLL_LOCKED,
  input wire ptdxr_test_src_t    TEST_SRC,
  input wire logic               LOCK_PIN,
  input wire logic [PRESC_W-1:0] PRESCALER_CODE,
  input wire logic [3:0]         PRESCALER_RATIO,
  input wire logic               PRESCALER_INVALID,
  input wire logic               RX_RESET,
  input wire ptdxr_analog_cfg_t  ANALOG_CFG
);
  logic [1:0] up_r;
  logic [7:0] r17_r, r18_r, r1a_r, r1b_r;
  logic [3:0] hi_r;
  wire logic  rel = (up_r == 2'h3);
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      up_r  <= 2'h0;
      r17_r <= 8'h00;
      r18_r <= 8'h20;
      r1a_r <= 8'h00;
      r1b_r <= 8'h80;
      hi_r  <= 4'h0;
    end else begin
      up_r <= rel ? up_r : up_r + 2'h1;
      if (REG_WR && REG_ADDR == 8'h17) r17_r <= REG_WDATA & 8'h0E;
      if (REG_WR && REG_ADDR == 8'h18) r18_r <= REG_WDATA & 8'hE0;
      if (REG_WR && REG_ADDR == 8'h1A) r1a_r <= REG_WDATA & 8'h7D;
      if (REG_WR && REG_ADDR == 8'h1B) r1b_r <= REG_WDATA & 8'hBF;
      hi_r <= ((REG_WR && REG_ADDR == 8'h1A && REG_WDATA[7]) || !RX_RESET) ? 4'h0 : hi_r + 4'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  property p_lock; (rel && !r17_r[3] && $stable(PLL_LOCKED)) [*4] |-> LOCK_PIN == PLL_LOCKED;
  endproperty
  a_lock: assert property (p_lock) else $error("lock pin not lock status");
  property p_mux; (rel && r17_r[3] && $stable(r17_r) && $stable(TEST_SRC)) [*4]
    |-> LOCK_PIN == TEST_SRC[r17_r[2:1]]; endproperty
  a_mux: assert property (p_mux) else $error("lock pin wrong test source");
  property p_ratio; PRESCALER_INVALID == (PRESCALER_CODE == 3'h0) && PRESCALER_RATIO ==
    (PRESCALER_INVALID ? 4'h0 : {1'b0, PRESCALER_CODE} + 4'h4); endproperty
  a_ratio: assert property (p_ratio) else $error("prescaler ratio");
  property p_presc; rel |=> PRESCALER_CODE == ($past(OUTDIV_OVERRIDE) ?
    $past(r18_r[7:5]) : $past(PIN_PRESCALER_CODE)); endproperty
  a_presc: assert property (p_presc) else $error("prescaler source");
  property p_rxlen; $fell(RX_RESET) |-> hi_r == RX_HOLD; endproperty
  a_rxlen: assert property (p_rxlen) else $error("receiver reset length");
  property p_bg; rel |=> ANALOG_CFG.bandgap_auto == !$past(r1a_r[0]) && ANALOG_CFG.bandgap_code
    == ($past(r1a_r[0]) ? $past(r1a_r[6:2]) : 5'h00); endproperty
  a_bg: assert property (p_bg) else $error("band gap setting");
  property p_xt; rel |=> ANALOG_CFG.crystal_resonator_input_auto == $past(r1b_r[7]) && ANALOG_CFG.crystal_resonator_input_code
    == ($past(r1b_r[7]) ? 6'h00 : $past(r1b_r[5:0])); endproperty
  a_xt: assert property (p_xt) else $error("crystal setting");
  property p_cap; ANALOG_CFG.crystal_resonator_input_cap_quarter_pf == ~ANALOG_CFG.crystal_resonator_input_code; endproperty
  a_cap: assert property (p_cap) else $error("crystal capacitance");
endmodule : ptdxr_regs_checker
bind ptdxr_regs ptdxr_regs_checker #(.RX_HOLD(RX_HOLD)) i_chk (
  .CLOCK(CLOCK), .NRST(NRST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .OUTDIV_OVERRIDE(OUTDIV_OVERRIDE),
  .PIN_PRESCALER_CODE(PIN_PRESCALER_CODE), .PLL_LOCKED(PLL_LOCKED), .TEST_SRC(TEST_SRC),
  .LOCK_PIN(LOCK_PIN), .PRESCALER_CODE(PRESCALER_CODE), .PRESCALER_RATIO(PRESCALER_RATIO),
  .PRESCALER_INVALID(PRESCALER_INVALID), .RX_RESET(RX_RESET), .ANALOG_CFG(ANALOG_CFG));
`default_nettype wire

//--- test_pll_test_divider_crystal_resonator_input_regs.sv
// self-checking bench for the register slice.
// assumes ptdxr_regs with a shortened receiver reset hold.
`timescale 1ns/1ps
`default_nettype none
module test_pll_test_divider_crystal_resonator_input_regs
  import ptdxr_pkg::*;
;
  localparam int HOLD = 3;
  logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, outdiv = 1'b0, locked = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, ra, rd, m [256];
  logic [2:0] pin_code = 3'h0, presc_code;
  logic [3:0] ratio;
  logic lock_pin, presc_inv, rx_rst, rd_seen = 1'b0;
  ptdxr_test_src_t src = 4'h0;
  ptdxr_analog_cfg_t acfg;
  logic [15:0] exp_q [$], note;
  int n_errors = 0, compares = 0, cyc = 0, n;
  ptdxr_regs #(.RX_HOLD(HOLD)) i_dut (
    .CLOCK(clock), .NRST(nrst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .OUTDIV_OVERRIDE(outdiv),
    .PIN_PRESCALER_CODE(pin_code), .PLL_LOCKED(locked), .TEST_SRC(src), .LOCK_PIN(lock_pin),
    .PRESCALER_CODE(presc_code), .PRESCALER_RATIO(ratio), .PRESCALER_INVALID(presc_inv),
    .RX_RESET(rx_rst), .ANALOG_CFG(acfg));
  always #10 clock = ~clock;
  task automatic chk(input logic [7:0] e, g, input string nm);
    compares++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h17: return 8'h0E;
      8'h18: return 8'hE0;
      8'h1A: return 8'h7D;
      8'h1B: return 8'hBF;
      default: return 8'h00;
    endcase
  endfunction : wmask
  // one strobed access; reads leave their expectation in the queue
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    if (w) m[a] = d & wmask(a);
    else exp_q.push_back({a, m[a]});
    @(negedge clock);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : acc
  always @(posedge clock) rd_seen <= reg_rd;
  always @(negedge clock) begin
    if (rd_seen) begin
      note = exp_q.pop_front();
      chk(note[7:0], rdata, "read data");
    end
  end
  task automatic conclude;
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(87460));
    for (int i = 0; i < 256; i++) m[i] = 8'h00;
    m[8'h18] = 8'h20;
    m[8'h1B] = 8'h80;
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    for (int i = 8'h16; i <= 8'h1F; i++) acc(1'b0, 8'(i), 8'h00);
    chk(8'h3F, 8'(acfg.crystal_resonator_input_cap_quarter_pf), "cap");
    for (int i = 0; i < 60; i++) begin
      ra = 8'h15 + 8'($urandom_range(11));
      rd = 8'($urandom);
      if (ra == 8'h1B) rd[6] = 1'b0;
      if (ra == 8'h1A) rd[7] = 1'b0;
      outdiv = 1'($urandom);
      pin_code = 3'($urandom);
      locked = 1'($urandom);
      acc(1'b1, ra, rd);
      acc(1'b0, ra, 8'h00);
    end
    outdiv = 1'b1;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 8'h18, {3'(c), 5'h1F});
      @(negedge clock);
      chk(c ? 8'(c + 4) : 8'h00, 8'(ratio), "ratio");
      chk(8'(c == 0), 8'(presc_inv), "invalid");
      outdiv = 1'b0;
      pin_code = 3'(7 - c);
      @(negedge clock);
      chk(8'(7 - c), 8'(presc_code), "pin code");
      outdiv = 1'b1;
    end
    for (int s = 0; s < 4; s++) begin
      src = 4'($urandom);
      acc(1'b1, 8'h17, 8'(8 | s << 1));
      repeat (5) @(negedge clock);
      chk(8'(src[s]), 8'(lock_pin), "lock pin");
    end
    locked = 1'b1;
    src = 4'h0;
    acc(1'b1, 8'h17, 8'h06);
    repeat (5) @(negedge clock);
    chk(8'h01, 8'(lock_pin), "lock status");
    acc(1'b1, 8'h1A, 8'hFD);
    chk(8'h01, 8'(rx_rst), "receiver reset");
    n = 0;
    repeat (8) begin
      n += rx_rst;
      @(negedge clock);
    end
    chk(8'(HOLD), 8'(n), "reset pulse");
    chk(8'h1F, 8'({acfg.bandgap_auto, acfg.bandgap_code}), "band gap");
    acc(1'b0, 8'h1A, 8'h00);
    acc(1'b1, 8'h1B, 8'h05);
    @(negedge clock);
    chk(8'h3A, 8'(acfg.crystal_resonator_input_cap_quarter_pf), "cap");
    chk(8'h05, 8'({acfg.crystal_resonator_input_auto, acfg.crystal_resonator_input_code}), "crystal");
    acc(1'b0, 8'h1B, 8'h00);
    repeat (3) @(negedge clock);
    conclude();
  end
endmodule : test_pll_test_divider_crystal_resonator_input_regs
`default_nettype wire
